// ---- rtl/cie_pkg.sv ----
// package for the comparator interrupt enable block: offsets, fields, reset values
// assumes a 32-bit axi4-lite register bus on a single clock
package cie_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] CIE_OFF_SET = 12'h0304; // write-one-to-set enables
	localparam logic [11:0] CIE_OFF_CLR = 12'h0308; // write-one-to-clear enables
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CIE_BIT_READY = 0; // ready event enable
	localparam int CIE_BIT_DOWN = 1; // downward crossing enable
	localparam int CIE_BIT_UP = 2; // upward crossing enable
	localparam int CIE_BIT_CROSS = 3; // any crossing enable
	localparam int CIE_NUM_EV = 4; // number of events
	localparam logic [3:0] CIE_EN_RESET = 4'h0; // all enables off
	localparam logic [1:0] CIE_RESP_OKAY = 2'h0; // okay response
	localparam logic [1:0] CIE_RESP_SLVERR = 2'h2; // unmapped address
endpackage

// ---- rtl/cie_en_if.sv ----
// interface carrying enable updates between the bus slave and the enable bank
// assumes both ends share aclk
`timescale 1ns/1ps
interface cie_en_if;
	logic [3:0] set_mask; // one-cycle pulse bits to set
	logic [3:0] clr_mask; // one-cycle pulse bits to clear
	logic [3:0] enables; // current enable state
	modport bank (input set_mask, input clr_mask, output enables);
	modport ctrl (output set_mask, output clr_mask, input enables);
endinterface

// ---- rtl/cie_en_bank.sv ----
// enable flip-flops of the comparator interrupts, one per event
// assumes set and clear masks are single-cycle pulses on aclk
`timescale 1ns/1ps
module cie_en_bank
	import cie_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	cie_en_if.bank en
);
	// ----------------------------------------
	// per-event enable bits
	// ----------------------------------------
	logic [3:0] en_q; // stored enables
	genvar g;
	generate
		for (g = 0; g < CIE_NUM_EV; g++) begin : g_bit
			// set wins if software hits both in one cycle, never happens on one bus write
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					en_q[g] <= CIE_EN_RESET[g];
				end else if (en.set_mask[g]) begin
					en_q[g] <= 1'b1;
				end else if (en.clr_mask[g]) begin
					en_q[g] <= 1'b0;
				end
			end
		end
	endgenerate
	assign en.enables = en_q; // zero written leaves bit alone
endmodule

// ---- rtl/cie_top.sv ----
// Notes on behaviour
// - set-register ready bit enables ready interrupt
// - set-register down bit enables downward interrupt
// - set-register up bit enables upward interrupt
// - set-register cross bit enables crossing interrupt
// - clear-register ready bit disables ready interrupt
// - clear-register down bit disables downward interrupt
// - clear-register up bit disables upward interrupt
// - clear-register cross bit disables crossing interrupt
//
// top of the comparator interrupt enable block with an axi4-lite slave
// assumes event_pending comes from logic on aclk
`timescale 1ns/1ps
module cie_top
	import cie_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] event_pending,
	output logic irq
);
	// ----------------------------------------
	// enable bank
	// ----------------------------------------
	cie_en_if en_bus (); // set, clear and state of the enables
	cie_en_bank i_cie_en_bank (
		.aclk(aclk),
		.aresetn(aresetn),
		.en(en_bus.bank)
	);

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	logic aw_held; // address captured
	logic w_held; // data captured
	logic [11:0] aw_addr; // captured address
	logic [3:0] w_bits; // captured low data bits
	logic w_lane0; // byte lane 0 written
	wire aw_take = s_axi_awvalid && s_axi_awready; // address handshake
	wire w_take = s_axi_wvalid && s_axi_wready; // data handshake
	wire do_write = aw_held && w_held && !s_axi_bvalid; // both halves present
	wire hit_set = (aw_addr == CIE_OFF_SET); // set-register selected
	wire hit_clr = (aw_addr == CIE_OFF_CLR); // clear-register selected
	wire wr_ok = hit_set || hit_clr; // mapped write
	wire [3:0] wr_bits = w_lane0 ? w_bits : 4'h0; // strobe gates the field byte
	assign en_bus.set_mask = (do_write && hit_set) ? wr_bits : 4'h0;
	assign en_bus.clr_mask = (do_write && hit_clr) ? wr_bits : 4'h0;

	// address and data accepted in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_bits <= 4'h0;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
			s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[11:2], 2'b00};
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_bits <= s_axi_wdata[3:0];
				w_lane0 <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response, slave error on an unmapped address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CIE_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? CIE_RESP_OKAY : CIE_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	wire ar_take = s_axi_arvalid && s_axi_arready; // read handshake
	wire [11:0] ar_word = {s_axi_araddr[11:2], 2'b00}; // aligned address
	wire rd_ok = (ar_word == CIE_OFF_SET) || (ar_word == CIE_OFF_CLR); // mapped read
	wire [31:0] rd_word = {28'h000_0000, en_bus.enables};

	// one read at a time; arready drops while the answer stands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CIE_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
				s_axi_rresp <= rd_ok ? CIE_RESP_OKAY : CIE_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// interrupt output
	// ----------------------------------------
	wire next_irq = |(event_pending & en_bus.enables);

	// registered so the output comes straight from a flip-flop, one cycle late
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_set_ready;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_set && w_lane0 && w_bits[CIE_BIT_READY])
			|=> en_bus.enables[CIE_BIT_READY];
	endproperty
	a_set_ready: assert property (p_set_ready) else $error("ready enable not set");
	property p_set_down;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_set && w_lane0 && w_bits[CIE_BIT_DOWN])
			|=> en_bus.enables[CIE_BIT_DOWN];
	endproperty
	a_set_down: assert property (p_set_down) else $error("down enable not set");
	property p_set_up;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_set && w_lane0 && w_bits[CIE_BIT_UP])
			|=> en_bus.enables[CIE_BIT_UP];
	endproperty
	a_set_up: assert property (p_set_up) else $error("up enable not set");
	property p_set_cross;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_set && w_lane0 && w_bits[CIE_BIT_CROSS])
			|=> en_bus.enables[CIE_BIT_CROSS];
	endproperty
	a_set_cross: assert property (p_set_cross) else $error("cross enable not set");
	property p_clr_ready;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_clr && w_lane0 && w_bits[CIE_BIT_READY])
			|=> !en_bus.enables[CIE_BIT_READY];
	endproperty
	a_clr_ready: assert property (p_clr_ready) else $error("ready enable not cleared");
	property p_clr_down;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_clr && w_lane0 && w_bits[CIE_BIT_DOWN])
			|=> !en_bus.enables[CIE_BIT_DOWN];
	endproperty
	a_clr_down: assert property (p_clr_down) else $error("down enable not cleared");
	property p_clr_up;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_clr && w_lane0 && w_bits[CIE_BIT_UP])
			|=> !en_bus.enables[CIE_BIT_UP];
	endproperty
	a_clr_up: assert property (p_clr_up) else $error("up enable not cleared");
	property p_clr_cross;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_clr && w_lane0 && w_bits[CIE_BIT_CROSS])
			|=> !en_bus.enables[CIE_BIT_CROSS];
	endproperty
	a_clr_cross: assert property (p_clr_cross) else $error("cross enable not cleared");
	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		(en_bus.set_mask == 4'h0 && en_bus.clr_mask == 4'h0)
			|=> $stable(en_bus.enables);
	endproperty
	a_hold: assert property (p_hold) else $error("enables changed without a write");
	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (irq == |($past(event_pending) & $past(en_bus.enables)));
	endproperty
	a_irq: assert property (p_irq) else $error("irq does not follow enabled pending");
	// read data is the enable state of the take edge, whichever register is addressed
	property p_read_data;
		@(posedge aclk) disable iff (!aresetn)
		(ar_take && rd_ok) |=> (s_axi_rdata == {28'h000_0000, $past(en_bus.enables)});
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data wrong");
	// a set write leaves every bit written as zero untouched
	property p_set_keep;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_set)
			|=> ((en_bus.enables & ~$past(en_bus.set_mask))
				== ($past(en_bus.enables) & ~$past(en_bus.set_mask)));
	endproperty
	a_set_keep: assert property (p_set_keep) else $error("set write changed a zero bit");
	// a clear write leaves every bit written as zero untouched
	property p_clr_keep;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && hit_clr)
			|=> ((en_bus.enables & ~$past(en_bus.clr_mask))
				== ($past(en_bus.enables) & ~$past(en_bus.clr_mask)));
	endproperty
	a_clr_keep: assert property (p_clr_keep) else $error("clear write changed a zero bit");
endmodule

// ---- testbench/comparator_interrupt_enable_bench.sv ----
// self-checking bench for the comparator interrupt enable block
// assumes cie_top with an axi4-lite slave on a single 50 mhz clock
`timescale 1ns/1ps
module comparator_interrupt_enable_bench;
	import cie_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic aclk = 1'b0, aresetn = 1'b0; // clock and active low reset
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0, event_pending = '0, en = CIE_EN_RESET; // en is the bench model
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_total = 0, n_tests = 0, cyc = 0;
	always #10 aclk = ~aclk;
	cie_top i_cie_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .event_pending(event_pending), .irq(irq));
	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			summarize();
		end
	end
	// expected enables after one write, zeros leave bits alone
	function automatic logic [3:0] next_en(logic [11:0] a, logic [31:0] d, logic [3:0] s,
		logic [3:0] e);
		if (!s[0]) return e;
		if (a == CIE_OFF_SET) return e | d[3:0];
		if (a == CIE_OFF_CLR) return e & ~d[3:0];
		return e;
	endfunction
	// ----------------------------------------
	// bus tasks, entered just after a rising edge
	// ----------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		bit aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 0;
			end
		end
		s_axi_bready <= 1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		check("bresp", s_axi_bresp, er);
		if (er === CIE_RESP_OKAY) en = next_en(a, d, s, en);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		check("rdata", s_axi_rdata, ed);
		check("rresp", s_axi_rresp, er);
	endtask
	// both registers must show the same enable state
	task automatic rd_both();
		rd(CIE_OFF_SET, {28'h000_0000, en}, CIE_RESP_OKAY);
		rd(CIE_OFF_CLR, {28'h000_0000, en}, CIE_RESP_OKAY);
	endtask
	// irq follows pending and enables one cycle later
	task automatic irq_chk(input logic [3:0] p);
		event_pending <= p;
		repeat (2) @(posedge aclk);
		check("irq", {31'h0, irq}, {31'h0, |(p & en)});
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [11:0] a;
		void'($urandom(32'h7df9));
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd_both();
		irq_chk(4'hf);
		$display("reset values done");
		// each field set then cleared alone, irq seen for each
		for (int i = 0; i < CIE_NUM_EV; i++) begin
			wr(CIE_OFF_SET, 32'h1 << i, 4'h1, CIE_RESP_OKAY);
			rd_both();
			irq_chk(4'h1 << i);
			wr(CIE_OFF_CLR, 32'h1 << i, 4'h1, CIE_RESP_OKAY);
			rd_both();
			irq_chk(4'hf);
		end
		$display("single fields done");
		// zeros and a missing byte lane change nothing, unmapped refused
		wr(CIE_OFF_SET, 32'h0000_000f, 4'hf, CIE_RESP_OKAY);
		wr(CIE_OFF_SET, 32'h0000_0000, 4'hf, CIE_RESP_OKAY);
		wr(CIE_OFF_CLR, 32'h0000_000f, 4'he, CIE_RESP_OKAY);
		wr(12'h300, 32'h0000_000f, 4'hf, CIE_RESP_SLVERR);
		rd_both();
		rd(12'h30c, 32'h0000_0000, CIE_RESP_SLVERR);
		$display("corner cases done");
		// random traffic against the model
		repeat (30) begin
			a = $urandom_range(1) ? CIE_OFF_SET : CIE_OFF_CLR;
			wr(a, $urandom, 4'($urandom), CIE_RESP_OKAY);
			rd_both();
			irq_chk(4'($urandom));
		end
		$display("random traffic done");
		// reset in mid-run with every enable on: all must come back off
		wr(CIE_OFF_SET, 32'h0000_000f, 4'h1, CIE_RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		en = CIE_EN_RESET;
		@(posedge aclk);
		rd_both();
		irq_chk(4'hf);
		$display("mid-run reset done");
		summarize();
	end
endmodule
